// ==== srw_pkg.sv ====
// Package: shared constants and types for the slave reset and watchdog block
`default_nettype none
package srw_pkg;
  // Clock
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
  // Times in ms
  localparam int unsigned WD_T1_MS         = 1000;
  localparam int unsigned WD_T2_MS         = 2000;
  localparam int unsigned WD_T3_MS         = 4000;
  localparam int unsigned HARD_OFF_MS      = 10;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL         = 8'h00;
  localparam logic [7:0]  OFS_WD_CFG       = 8'h04;
  localparam logic [7:0]  OFS_GAUGE        = 8'h08;
  localparam logic [7:0]  OFS_STATUS       = 8'h0c;
  localparam logic [7:0]  OFS_WD_CLR       = 8'h10;
  // Control bits (write one to act)
  localparam int unsigned B_SOFT           = 0;
  localparam int unsigned B_HARD           = 1;
  localparam int unsigned B_COMB           = 2;
  localparam int unsigned B_BOOT           = 3;
  localparam int unsigned B_UART_LEAVE     = 4;
  // Watchdog config fields
  localparam int unsigned F_SEL_LO         = 0;
  localparam int unsigned F_KIND_LO        = 2;
  localparam logic [1:0]  WD_SEL_OFF       = 2'h0;
  localparam logic [1:0]  WD_SEL_T1        = 2'h1;
  localparam logic [1:0]  WD_SEL_T2        = 2'h2;
  localparam logic [1:0]  KIND_SOFT        = 2'h0;
  localparam logic [1:0]  KIND_HARD        = 2'h1;
  localparam logic [3:0]  WD_CFG_RESET     = 4'h0;
  // Gauge bits
  localparam int unsigned B_GAUGE_OVR      = 0;
  localparam int unsigned B_GAUGE_VAL      = 1;
  // Status bits
  localparam int unsigned S_WD_PEND        = 0;
  localparam int unsigned S_UART           = 1;
  localparam int unsigned S_HARD_BUSY      = 2;
  localparam int unsigned S_WD_ACTIVE      = 3;
  localparam int unsigned S_TEMP_HOLD      = 4;
  // Power-line system request commands
  typedef enum logic [2:0] {
    CMD_NONE, CMD_GAUGE, CMD_SOFT, CMD_HARD, CMD_COMBINED, CMD_BOOT
  } srw_cmd_t;
endpackage
`default_nettype wire

// ==== srw_wd_if.sv ====
// Interface between the reset controller and its watchdog timer
`default_nettype none
interface srw_wd_if;
  logic [1:0] sel;
  logic       active;
  logic       service;
  logic       restart;
  logic       expire;
  modport wdog (input sel, input active, input service, input restart, output expire);
  modport ctrl (output sel, output active, output service, output restart, input expire);
endinterface
`default_nettype wire

// ==== srw_sync.sv ====
// Two-flop synchroniser for a vector of independent levels
`default_nettype none
module srw_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ==== srw_wdog.sv ====
// Watchdog timer with selectable timeout
`default_nettype none
module srw_wdog #(
  parameter int unsigned T1_CYC = 1,
  parameter int unsigned T2_CYC = 1,
  parameter int unsigned T3_CYC = 1
) (
  input  wire logic pclk,
  input  wire logic presetn,
  srw_wd_if.wdog    wd
);
  logic [31:0] count_r;
  logic [1:0]  sel_q_r;
  logic        expire_r;
  logic [31:0] limit;

  function automatic logic [31:0] limit_of(input logic [1:0] s);
    case (s)
      srw_pkg::WD_SEL_T1: limit_of = T1_CYC;
      srw_pkg::WD_SEL_T2: limit_of = T2_CYC;
      default:            limit_of = T3_CYC;
    endcase
  endfunction

  assign limit     = limit_of(wd.sel);
  assign wd.expire = expire_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q_r <= srw_pkg::WD_SEL_OFF;
    end else begin
      sel_q_r <= wd.sel;
    end
  end

  // Count from the latest service; restart on a select change and after an issued reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r  <= '0;
      expire_r <= 1'b0;
    end else begin
      expire_r <= 1'b0;
      if (!wd.active || wd.sel == srw_pkg::WD_SEL_OFF || wd.service || wd.restart ||
          sel_q_r != wd.sel) begin
        count_r <= '0;
      end else if (count_r >= limit - 32'h1) begin
        count_r  <= '0;
        expire_r <= 1'b1;
      end else begin
        count_r <= count_r + 32'h1;
      end
    end
  end

  property p_wd_service;
    @(posedge pclk) disable iff (!presetn)
    wd.service |=> count_r == 32'h0;
  endproperty
  a_wd_service: assert property (p_wd_service) else $error("count not cleared by service");

  property p_wd_expire;
    @(posedge pclk) disable iff (!presetn)
    $rose(expire_r) |-> $past(count_r) == $past(limit) - 32'h1 && $past(wd.active);
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("expiry not at full timeout");

  property p_wd_off;
    @(posedge pclk) disable iff (!presetn)
    wd.sel == srw_pkg::WD_SEL_OFF |=> !expire_r;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("expiry while disabled");
endmodule
`default_nettype wire

// ==== srw_ctrl.sv ====
// Slave reset controller and watchdog with APB register access
`default_nettype none
module srw_ctrl #(
  parameter int unsigned WD_T1_CYC    = srw_pkg::WD_T1_MS * srw_pkg::CYC_PER_MS,
  parameter int unsigned WD_T2_CYC    = srw_pkg::WD_T2_MS * srw_pkg::CYC_PER_MS,
  parameter int unsigned WD_T3_CYC    = srw_pkg::WD_T3_MS * srw_pkg::CYC_PER_MS,
  parameter int unsigned HARD_OFF_CYC = srw_pkg::HARD_OFF_MS * srw_pkg::CYC_PER_MS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_code,
  input  wire logic        uvlo_in,
  input  wire logic        off_mode_in,
  input  wire logic        seal_mode_in,
  input  wire logic        temp_reset_in,
  output logic             gauge_reset,
  output logic             gauge_enable,
  output logic             link_reset,
  output logic             supply_enable,
  output logic             charger_enable,
  output logic             uart_mode
);
  typedef enum logic {ST_IDLE, ST_HARD_OFF} srw_state_t;

  srw_state_t  state_r;
  logic [31:0] hard_cnt_r;
  logic        boot_after_r;
  logic        uart_r;
  logic        link_reset_r;
  logic        gauge_reset_r;
  logic [3:0]  wd_cfg_r;
  logic        g_ovr_r;
  logic        g_val_r;
  logic        wd_pend_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic [3:0]  pins_s;
  logic        uvlo_s;
  logic        off_s;
  logic        seal_s;
  logic        temp_s;
  logic        xfer_done;
  logic        wr_done;
  logic        rd_done;
  logic [4:0]  ctrl_wr;
  logic        addr_ok;
  logic        wd_active;
  logic        wd_blocked;
  logic        wd_issue;
  logic [1:0]  wd_kind;
  logic        do_soft;
  logic        do_hard;
  logic        do_boot;
  logic        do_gauge;
  logic [31:0] rd_val;
  srw_wd_if    wdi ();

  function automatic logic is_cmd(input logic v, input logic [2:0] c, input srw_pkg::srw_cmd_t k);
    is_cmd = v && (c == k);
  endfunction

  srw_sync #(
    .W (4)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({temp_reset_in, seal_mode_in, off_mode_in, uvlo_in}),
    .q       (pins_s)
  );
  assign uvlo_s = pins_s[0];
  assign off_s  = pins_s[1];
  assign seal_s = pins_s[2];
  assign temp_s = pins_s[3];

  // APB slave: one wait state, data registered
  assign xfer_done = psel && penable && pready_r;
  assign wr_done   = xfer_done && pwrite && !pslverr_r;
  assign rd_done   = xfer_done && !pwrite && !pslverr_r;
  assign addr_ok   = paddr == srw_pkg::OFS_CTRL || paddr == srw_pkg::OFS_WD_CFG ||
                     paddr == srw_pkg::OFS_GAUGE || paddr == srw_pkg::OFS_STATUS ||
                     paddr == srw_pkg::OFS_WD_CLR;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r && pready_r;
  assign prdata    = prdata_r;

  always_comb begin
    rd_val = '0;
    case (paddr)
      srw_pkg::OFS_WD_CFG: rd_val[3:0] = wd_cfg_r;
      srw_pkg::OFS_GAUGE: begin
        rd_val[srw_pkg::B_GAUGE_OVR] = g_ovr_r;
        rd_val[srw_pkg::B_GAUGE_VAL] = g_val_r;
      end
      srw_pkg::OFS_STATUS, srw_pkg::OFS_WD_CLR: begin
        rd_val[srw_pkg::S_WD_PEND]   = wd_pend_r;
        rd_val[srw_pkg::S_UART]      = uart_r;
        rd_val[srw_pkg::S_HARD_BUSY] = state_r == ST_HARD_OFF;
        rd_val[srw_pkg::S_WD_ACTIVE] = wd_active;
        rd_val[srw_pkg::S_TEMP_HOLD] = temp_s;
      end
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r <= psel && penable && !pready_r;
      if (psel && penable && !pready_r) begin
        pslverr_r <= !addr_ok || (pwrite && (paddr == srw_pkg::OFS_STATUS ||
                                             paddr == srw_pkg::OFS_WD_CLR));
        prdata_r  <= pwrite ? 32'h0 : rd_val;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cfg_r <= srw_pkg::WD_CFG_RESET;
      g_ovr_r  <= 1'b0;
      g_val_r  <= 1'b0;
    end else if (wr_done) begin
      if (paddr == srw_pkg::OFS_WD_CFG) begin
        wd_cfg_r <= pwdata[3:0];
      end
      if (paddr == srw_pkg::OFS_GAUGE) begin
        g_ovr_r <= pwdata[srw_pkg::B_GAUGE_OVR];
        g_val_r <= pwdata[srw_pkg::B_GAUGE_VAL];
      end
    end
  end

  assign ctrl_wr      = (wr_done && paddr == srw_pkg::OFS_CTRL) ? pwdata[4:0] : 5'h0;
  assign gauge_enable = g_ovr_r ? g_val_r : 1'b1;

  // Watchdog hookup
  assign wd_active   = !(uvlo_s || off_s || seal_s);
  assign wd_kind     = wd_cfg_r[srw_pkg::F_KIND_LO +: 2];
  assign wd_blocked  = uart_r || state_r != ST_IDLE || link_reset_r || temp_s;
  assign wd_issue    = wd_pend_r && !wd_blocked && wd_active;
  assign wdi.sel     = wd_cfg_r[srw_pkg::F_SEL_LO +: 2];
  assign wdi.active  = wd_active;
  assign wdi.service = rd_done && paddr == srw_pkg::OFS_WD_CLR;
  assign wdi.restart = wd_issue;

  srw_wdog #(
    .T1_CYC (WD_T1_CYC),
    .T2_CYC (WD_T2_CYC),
    .T3_CYC (WD_T3_CYC)
  ) u_wdog (
    .pclk    (pclk),
    .presetn (presetn),
    .wd      (wdi.wdog)
  );

  // Expiry is held until the blocking condition ends; expiry beats issue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_pend_r <= 1'b0;
    end else if (!wd_active) begin
      wd_pend_r <= 1'b0;
    end else if (wdi.expire) begin
      wd_pend_r <= 1'b1;
    end else if (wd_issue) begin
      wd_pend_r <= 1'b0;
    end
  end

  // Merge local writes, line commands and the watchdog into reset actions
  assign do_gauge = is_cmd(cmd_valid, cmd_code, srw_pkg::CMD_GAUGE) ||
                    (wr_done && paddr == srw_pkg::OFS_GAUGE &&
                     pwdata[srw_pkg::B_GAUGE_OVR] && !pwdata[srw_pkg::B_GAUGE_VAL]);
  assign do_soft  = ctrl_wr[srw_pkg::B_SOFT] || ctrl_wr[srw_pkg::B_COMB] ||
                    is_cmd(cmd_valid, cmd_code, srw_pkg::CMD_SOFT) ||
                    is_cmd(cmd_valid, cmd_code, srw_pkg::CMD_COMBINED) ||
                    (wd_issue && wd_kind != srw_pkg::KIND_HARD);
  assign do_boot  = ctrl_wr[srw_pkg::B_BOOT] ||
                    is_cmd(cmd_valid, cmd_code, srw_pkg::CMD_BOOT);
  assign do_hard  = ctrl_wr[srw_pkg::B_HARD] || ctrl_wr[srw_pkg::B_COMB] || do_boot ||
                    is_cmd(cmd_valid, cmd_code, srw_pkg::CMD_HARD) ||
                    is_cmd(cmd_valid, cmd_code, srw_pkg::CMD_COMBINED) ||
                    (wd_issue && wd_kind != srw_pkg::KIND_SOFT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_reset_r  <= 1'b0;
      gauge_reset_r <= 1'b0;
    end else begin
      link_reset_r  <= do_soft;
      gauge_reset_r <= do_gauge;
    end
  end

  // Hard reset: supply and charger off for the off time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= ST_IDLE;
      hard_cnt_r   <= '0;
      boot_after_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (do_hard) begin
            state_r      <= ST_HARD_OFF;
            hard_cnt_r   <= '0;
            boot_after_r <= do_boot;
          end
        end
        ST_HARD_OFF: begin
          if (hard_cnt_r >= HARD_OFF_CYC - 32'h1) begin
            state_r <= ST_IDLE;
          end else begin
            hard_cnt_r <= hard_cnt_r + 32'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // UART mode entered at the end of a boot hard reset, left by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_r <= 1'b0;
    end else if (state_r == ST_HARD_OFF && hard_cnt_r >= HARD_OFF_CYC - 32'h1 && boot_after_r) begin
      uart_r <= 1'b1;
    end else if (ctrl_wr[srw_pkg::B_UART_LEAVE]) begin
      uart_r <= 1'b0;
    end
  end

  assign supply_enable  = state_r == ST_IDLE;
  assign charger_enable = state_r == ST_IDLE;
  assign link_reset     = link_reset_r;
  assign gauge_reset    = gauge_reset_r;
  assign uart_mode      = uart_r;

  sequence s_boot_start;
    state_r == ST_IDLE && do_boot;
  endsequence

  property p_soft;
    @(posedge pclk) disable iff (!presetn)
    is_cmd(cmd_valid, cmd_code, srw_pkg::CMD_SOFT) |=> link_reset && supply_enable;
  endproperty
  a_soft: assert property (p_soft) else $error("soft request without link reset");

  property p_gauge;
    @(posedge pclk) disable iff (!presetn)
    is_cmd(cmd_valid, cmd_code, srw_pkg::CMD_GAUGE) |=> gauge_reset && !link_reset;
  endproperty
  a_gauge: assert property (p_gauge) else $error("gauge request without gauge reset");

  property p_comb;
    @(posedge pclk) disable iff (!presetn)
    state_r == ST_IDLE && ctrl_wr[srw_pkg::B_COMB] |=> link_reset && !supply_enable;
  endproperty
  a_comb: assert property (p_comb) else $error("combined reset incomplete");

  property p_hard;
    @(posedge pclk) disable iff (!presetn)
    state_r == ST_IDLE && is_cmd(cmd_valid, cmd_code, srw_pkg::CMD_HARD)
      |=> !supply_enable && !charger_enable;
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset did not drop supply");

  property p_boot;
    @(posedge pclk) disable iff (!presetn)
    s_boot_start ##1 !supply_enable |-> !uart_mode;
  endproperty
  a_boot: assert property (p_boot) else $error("UART entered before hard reset");

  property p_uart_entry;
    @(posedge pclk) disable iff (!presetn)
    $rose(uart_mode) |-> $past(state_r) == ST_HARD_OFF && supply_enable;
  endproperty
  a_uart_entry: assert property (p_uart_entry) else $error("UART mode not after hard reset");

  property p_wd_hold;
    @(posedge pclk) disable iff (!presetn)
    wd_pend_r && wd_active && uart_mode ##1 wd_active |-> wd_pend_r && !link_reset_r;
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("watchdog reset not held");

  property p_wd_kind;
    @(posedge pclk) disable iff (!presetn)
    wd_issue && wd_kind == srw_pkg::KIND_SOFT |=> link_reset && supply_enable;
  endproperty
  a_wd_kind: assert property (p_wd_kind) else $error("watchdog reset kind wrong");

  property p_wd_inactive;
    @(posedge pclk) disable iff (!presetn)
    !wd_active |=> !wd_pend_r;
  endproperty
  a_wd_inactive: assert property (p_wd_inactive) else $error("watchdog active in lockout");
endmodule
`default_nettype wire

// ==== srw_line_model.sv ====
// Far power-line device model that sends system request commands
`default_nettype none
module srw_line_model (
  input  wire logic       pclk,
  output logic            cmd_valid,
  output logic      [2:0] cmd_code
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 3'h0;
  end

  // One-cycle command pulse; afterwards the code lines carry junk
  task automatic send(input logic [2:0] code);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;
  endtask
endmodule
`default_nettype wire

// ==== srw_ctrl_tb.sv ====
// Self-checking testbench for the slave reset and watchdog block
`default_nettype none
module srw_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int T1   = 20;
  localparam int T2   = 40;
  localparam int T3   = 80;
  localparam int HOFF = 5;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmd_valid;
  logic [2:0]  cmd_code;
  logic [2:0]  blk;
  logic        temp_rst;
  logic        gauge_reset;
  logic        gauge_enable;
  logic        link_reset;
  logic        supply_enable;
  logic        charger_enable;
  logic        uart_mode;
  int          err_count;
  int          checked;
  int          n_gauge;
  int          n_link;
  int          n_off;
  int          n_chg;

  srw_ctrl #(
    .WD_T1_CYC    (T1),
    .WD_T2_CYC    (T2),
    .WD_T3_CYC    (T3),
    .HARD_OFF_CYC (HOFF)
  ) dut_u (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .cmd_valid      (cmd_valid),
    .cmd_code       (cmd_code),
    .uvlo_in        (blk[0]),
    .off_mode_in    (blk[1]),
    .seal_mode_in   (blk[2]),
    .temp_reset_in  (temp_rst),
    .gauge_reset    (gauge_reset),
    .gauge_enable   (gauge_enable),
    .link_reset     (link_reset),
    .supply_enable  (supply_enable),
    .charger_enable (charger_enable),
    .uart_mode      (uart_mode)
  );

  srw_line_model line_u (
    .pclk      (pclk),
    .cmd_valid (cmd_valid),
    .cmd_code  (cmd_code)
  );

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // Counts pulses and off cycles seen at the outputs
  always @(posedge pclk) begin
    if (gauge_reset === 1'b1) n_gauge <= n_gauge + 1;
    if (link_reset === 1'b1) n_link <= n_link + 1;
    if (supply_enable === 1'b0) n_off <= n_off + 1;
    if (charger_enable === 1'b0) n_chg <= n_chg + 1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One APB transfer; the error response is judged as well
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic exp_err, output logic [31:0] q);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    chk("pslverr", 32'(pslverr), 32'(exp_err));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs();
    logic [31:0] q;
    xfer(srw_pkg::OFS_WD_CFG, 1'b0, 32'h0, 1'b0, q);
    chk("wd_cfg", q, 32'(srw_pkg::WD_CFG_RESET));
    xfer(srw_pkg::OFS_WD_CFG, 1'b1, 32'hc, 1'b0, q);
    xfer(srw_pkg::OFS_WD_CFG, 1'b0, 32'h0, 1'b0, q);
    chk("wd_cfg", q, 32'hc);
    xfer(srw_pkg::OFS_WD_CFG, 1'b1, 32'h0, 1'b0, q);
    xfer(srw_pkg::OFS_CTRL, 1'b0, 32'h0, 1'b0, q);
    chk("ctrl", q, 32'h0);
    xfer(8'h14, 1'b1, 32'h0, 1'b1, q);
    xfer(8'h14, 1'b0, 32'h0, 1'b1, q);
    xfer(srw_pkg::OFS_STATUS, 1'b1, 32'h1f, 1'b1, q);
    xfer(srw_pkg::OFS_WD_CLR, 1'b1, 32'h0, 1'b1, q);
    xfer(srw_pkg::OFS_STATUS, 1'b0, 32'h0, 1'b0, q);
    chk("status", q, 32'(1) << srw_pkg::S_WD_ACTIVE);
  endtask

  // Kind k: 0 gauge, 1 soft, 2 hard, 3 combined, 4 boot; s picks line or local
  task automatic run_reset(input int s, input int k);
    logic [31:0] q;
    int g;
    int l;
    int o;
    int c;
    g = n_gauge;
    l = n_link;
    o = n_off;
    c = n_chg;
    if (s == 0) line_u.send(3'(k + 1));
    else if (k == 0) xfer(srw_pkg::OFS_GAUGE, 1'b1, 32'h1, 1'b0, q);
    else xfer(srw_pkg::OFS_CTRL, 1'b1, 32'(1) << (k - 1), 1'b0, q);
    repeat (12) @(posedge pclk);
    chk("gauge_rst", n_gauge - g, 32'(k == 0));
    chk("link_rst", n_link - l, 32'(k == 1 || k == 3));
    chk("supply_off", n_off - o, (k >= 2) ? HOFF : 0);
    chk("charger_off", n_chg - c, (k >= 2) ? HOFF : 0);
    chk("uart_mode", 32'(uart_mode), 32'(k == 4));
    chk("gauge_en", 32'(gauge_enable), 32'(!(s == 1 && k == 0)));
    if (s == 1 && k == 0) xfer(srw_pkg::OFS_GAUGE, 1'b1, 32'h0, 1'b0, q);
    if (k == 4) xfer(srw_pkg::OFS_CTRL, 1'b1, 32'(1) << srw_pkg::B_UART_LEAVE, 1'b0, q);
  endtask

  // Serviced watchdog stays quiet, then expires with the chosen kind
  task automatic t_wd(input int k);
    logic [31:0] q;
    int l;
    int o;
    l = n_link;
    o = n_off;
    xfer(srw_pkg::OFS_WD_CFG, 1'b1, 32'((k << 2) | 1), 1'b0, q);
    repeat (5) begin
      repeat (8) @(posedge pclk);
      xfer(srw_pkg::OFS_WD_CLR, 1'b0, 32'h0, 1'b0, q);
    end
    repeat (16) @(posedge pclk);
    chk("wd_early", n_link - l + n_off - o, 0);
    repeat (10) @(posedge pclk);
    xfer(srw_pkg::OFS_WD_CFG, 1'b1, 32'h0, 1'b0, q);
    chk("wd_link", n_link - l, 32'(k != 1));
    chk("wd_off", n_off - o, (k != 0) ? HOFF : 0);
  endtask

  task automatic t_period(input int sel, input int lim);
    logic [31:0] q;
    int l;
    l = n_link;
    xfer(srw_pkg::OFS_WD_CFG, 1'b1, 32'(sel), 1'b0, q);
    repeat (lim) @(posedge pclk);
    chk("period_early", n_link - l, 0);
    repeat (5) @(posedge pclk);
    xfer(srw_pkg::OFS_WD_CFG, 1'b1, 32'h0, 1'b0, q);
    chk("period_fire", n_link - l, 1);
  endtask

  // Expiry held pending in UART mode (m=0) or temperature hold (m=1)
  task automatic t_pend(input int m);
    logic [31:0] q;
    int l;
    l = n_link;
    if (m == 1) temp_rst <= 1'b1;
    xfer(srw_pkg::OFS_WD_CFG, 1'b1, 32'h1, 1'b0, q);
    if (m == 0) line_u.send(3'h5);
    repeat (40) @(posedge pclk);
    chk("pend_quiet", n_link - l, 0);
    xfer(srw_pkg::OFS_STATUS, 1'b0, 32'h0, 1'b0, q);
    chk("pend_bit", 32'(q[srw_pkg::S_WD_PEND]), 1);
    chk("hold_bit", 32'(q[m == 1 ? srw_pkg::S_TEMP_HOLD : srw_pkg::S_UART]), 1);
    if (m == 1) temp_rst <= 1'b0;
    else xfer(srw_pkg::OFS_CTRL, 1'b1, 32'(1) << srw_pkg::B_UART_LEAVE, 1'b0, q);
    repeat (6) @(posedge pclk);
    xfer(srw_pkg::OFS_WD_CFG, 1'b1, 32'h0, 1'b0, q);
    chk("pend_fire", n_link - l, 1);
  endtask

  task automatic t_off();
    logic [31:0] q;
    int l;
    for (int i = 0; i < 3; i++) begin
      l = n_link;
      blk[i] <= 1'b1;
      repeat (3) @(posedge pclk);
      xfer(srw_pkg::OFS_WD_CFG, 1'b1, 32'h1, 1'b0, q);
      repeat (45) @(posedge pclk);
      xfer(srw_pkg::OFS_STATUS, 1'b0, 32'h0, 1'b0, q);
      chk("wd_active", 32'(q[srw_pkg::S_WD_ACTIVE]), 0);
      xfer(srw_pkg::OFS_WD_CFG, 1'b1, 32'h0, 1'b0, q);
      chk("off_quiet", n_link - l, 0);
      blk[i] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  initial begin
    err_count = 0;
    checked   = 0;
    n_gauge   = 0;
    n_link    = 0;
    n_off     = 0;
    n_chg     = 0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    blk       = 3'h0;
    temp_rst  = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_regs();
    for (int s = 0; s < 2; s++) for (int k = 0; k < 5; k++) run_reset(s, k);
    for (int k = 0; k < 4; k++) t_wd(k);
    t_period(2, T2);
    t_period(3, T3);
    t_pend(0);
    t_pend(1);
    t_off();
    final_report();
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
